/* File: verilog/lintmc_pkg.sv */
// Package of constants for the host-side transceiver mode controller
// Notes on behaviour
// - Controller drives transceiver-on low to put the transceiver to sleep.
// - Controller may enter normal mode without bus wake-up by raising transceiver-on.
// - Transmit low drives the bus dominant; transmit high leaves it recessive.
// - Controller services the watchdog by pulses; only rising edges count.
// - Bit timing on transmit and receive stays at or below 20 kBaud; the controller paces transmit only, receive passes straight through.
package lintmc_pkg;
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned BAUD_MAX        = 20_000;
   // Least bit time rounds up to whole cycles
   localparam int unsigned BIT_CYC         = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
   localparam int unsigned WD_HALF_CYC     = 16;
   localparam int unsigned WAKE_CONFIRM    = 4;
   localparam int unsigned CNT_W           = 12;
   localparam logic [CNT_W-1:0] BIT_CNT_MAX  = CNT_W'(BIT_CYC - 1);
   localparam logic [CNT_W-1:0] WD_CNT_MAX   = CNT_W'(WD_HALF_CYC - 1);
   localparam logic [CNT_W-1:0] WAKE_CNT_MAX = CNT_W'(WAKE_CONFIRM - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO     = 12'h000;

   typedef enum logic [1:0] {
      LINTMC_SLEEP,
      LINTMC_WAKE_SEEN,
      LINTMC_NORMAL
   } lintmc_mode_e;
endpackage

/* File: verilog/lintmc_ctrl.sv */
// Host-side controller driving a LIN transceiver's mode, data and watchdog pins
`timescale 1ns/1ps
module lintmc_ctrl (
   // Clock and reset
   input  wire logic   core_clk,
   input  wire logic   nrst,
   input  wire logic   clk_en,
   // User side
   input  wire logic   go_normal,
   input  wire logic   go_sleep,
   input  wire logic   tx_bit_valid,
   input  wire logic   tx_bit,
   output logic        tx_bit_ready,
   output logic        rx_bit,
   output logic        wake_event,
   output logic        normal_active,
   input  wire logic   wd_kick,
   input  wire logic   reg_enable,
   // Transceiver pins
   output logic        transceiver_on_input,
   output logic        txd,
   input  wire logic   rxd,
   output logic        watchdog_trigger,
   output logic        regulator_shutoff_in_n,
   input  wire logic   regulator_control_out
);
   import lintmc_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] rxd_s_r, rxd_s_nxt;
   logic [1:0] inh_s_r, inh_s_nxt;

   always_comb begin
      rxd_s_nxt = {rxd_s_r[0], rxd};
      inh_s_nxt = {inh_s_r[0], regulator_control_out};
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rxd_s_r <= 2'h3;
         inh_s_r <= 2'h0;
      end else if (clk_en) begin
         rxd_s_r <= rxd_s_nxt;
         inh_s_r <= inh_s_nxt;
      end
   end

   wire logic rxd_q = rxd_s_r[1];
   wire logic inh_q = inh_s_r[1];

   // ****************************************
   // Mode control
   // ****************************************
   lintmc_mode_e     mode_r, mode_nxt;
   logic [CNT_W-1:0] wake_cnt_r, wake_cnt_nxt;
   logic             en_r, en_nxt;
   logic             wake_ev_r, wake_ev_nxt;
   logic             nrm_r, nrm_nxt;

   always_comb begin
      mode_nxt     = mode_r;
      wake_cnt_nxt = wake_cnt_r;
      en_nxt       = en_r;
      wake_ev_nxt  = 1'b0;
      case (mode_r)
         LINTMC_SLEEP: begin
            en_nxt = 1'b0;
            // Wake seen as regulator control high plus receive held low
            if (inh_q && !rxd_q) begin
               if (wake_cnt_r == WAKE_CNT_MAX) begin
                  mode_nxt    = LINTMC_WAKE_SEEN;
                  wake_ev_nxt = 1'b1;
               end else begin
                  wake_cnt_nxt = wake_cnt_r + 12'h001;
               end
            end else begin
               wake_cnt_nxt = CNT_ZERO;
            end
            if (go_normal) begin
               // Normal entry wins; a wake found in the same cycle is moot
               mode_nxt     = LINTMC_NORMAL;
               en_nxt       = 1'b1;
               wake_ev_nxt  = 1'b0;
               wake_cnt_nxt = CNT_ZERO;
            end
         end
         LINTMC_WAKE_SEEN: begin
            // Fresh count if sleep is asked for again while the flag stands
            wake_cnt_nxt = CNT_ZERO;
            // Flag held by device until normal mode entered
            if (go_normal) begin
               mode_nxt = LINTMC_NORMAL;
               en_nxt   = 1'b1;
            end else if (go_sleep) begin
               mode_nxt = LINTMC_SLEEP;
            end
         end
         LINTMC_NORMAL: begin
            en_nxt       = 1'b1;
            wake_cnt_nxt = CNT_ZERO;
            if (go_sleep) begin
               mode_nxt = LINTMC_SLEEP;
               en_nxt   = 1'b0;
            end
         end
         default: begin
            mode_nxt = LINTMC_SLEEP;
            en_nxt   = 1'b0;
         end
      endcase
      nrm_nxt = (mode_nxt == LINTMC_NORMAL);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode_r     <= LINTMC_SLEEP;
         wake_cnt_r <= CNT_ZERO;
         en_r       <= 1'b0;
         wake_ev_r  <= 1'b0;
         nrm_r      <= 1'b0;
      end else if (clk_en) begin
         mode_r     <= mode_nxt;
         wake_cnt_r <= wake_cnt_nxt;
         en_r       <= en_nxt;
         wake_ev_r  <= wake_ev_nxt;
         nrm_r      <= nrm_nxt;
      end
   end

   // ****************************************
   // Transmit pacing and receive
   // ****************************************
   logic [CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
   logic             txd_r, txd_nxt;
   logic             rdy_r, rdy_nxt;
   logic             rx_r, rx_nxt;

   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      txd_nxt     = txd_r;
      rdy_nxt     = 1'b0;
      if (!nrm_r || !nrm_nxt) begin
         // Recessive from the edge that leaves normal mode, so the
         // transceiver is never switched off with a dominant bit on it
         txd_nxt     = 1'b1;
         bit_cnt_nxt = CNT_ZERO;
      end else if (bit_cnt_r != CNT_ZERO) begin
         // Each bit held at least one bit time
         bit_cnt_nxt = bit_cnt_r - 12'h001;
      end else begin
         rdy_nxt = !(tx_bit_valid && rdy_r);
         if (tx_bit_valid && rdy_r) begin
            txd_nxt     = tx_bit;
            bit_cnt_nxt = BIT_CNT_MAX;
         end
      end
      // Low receive means dominant or wake flag; both pass through
      rx_nxt = rxd_q;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_r <= CNT_ZERO;
         txd_r     <= 1'b1;
         rdy_r     <= 1'b0;
         rx_r      <= 1'b1;
      end else if (clk_en) begin
         bit_cnt_r <= bit_cnt_nxt;
         txd_r     <= txd_nxt;
         rdy_r     <= rdy_nxt;
         rx_r      <= rx_nxt;
      end
   end

   // ****************************************
   // Watchdog pulse and regulator inhibit
   // ****************************************
   logic [CNT_W-1:0] wd_cnt_r, wd_cnt_nxt;
   logic             wd_r, wd_nxt;
   logic             inhn_r, inhn_nxt;

   always_comb begin
      wd_cnt_nxt = wd_cnt_r;
      wd_nxt     = wd_r;
      if (wd_cnt_r != CNT_ZERO) begin
         wd_cnt_nxt = wd_cnt_r - 12'h001;
      end else if (wd_r) begin
         wd_nxt     = 1'b0;
         wd_cnt_nxt = WD_CNT_MAX;
      end else if (wd_kick) begin
         // Only the rising edge counts, so a full low-high pulse
         wd_nxt     = 1'b1;
         wd_cnt_nxt = WD_CNT_MAX;
      end
      inhn_nxt = reg_enable;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wd_cnt_r <= CNT_ZERO;
         wd_r     <= 1'b0;
         inhn_r   <= 1'b1;
      end else if (clk_en) begin
         wd_cnt_r <= wd_cnt_nxt;
         wd_r     <= wd_nxt;
         inhn_r   <= inhn_nxt;
      end
   end

   // ****************************************
   // Pin and status outputs
   // ****************************************

   always_comb begin
      transceiver_on_input   = en_r;
      txd                    = txd_r;
      tx_bit_ready           = rdy_r;
      rx_bit                 = rx_r;
      wake_event             = wake_ev_r;
      normal_active          = nrm_r;
      watchdog_trigger       = wd_r;
      regulator_shutoff_in_n = inhn_r;
   end
endmodule // lintmc_ctrl

/* File: test/lintmc_ctrl_properties.sv */
// Concurrent checks on the ports of the transceiver mode controller
`timescale 1ns/1ps
module lintmc_ctrl_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // User side
   input wire logic go_normal,
   input wire logic go_sleep,
   input wire logic tx_bit_valid,
   input wire logic tx_bit,
   input wire logic tx_bit_ready,
   input wire logic rx_bit,
   input wire logic wake_event,
   input wire logic normal_active,
   input wire logic reg_enable,
   // Transceiver pins
   input wire logic transceiver_on_input,
   input wire logic txd,
   input wire logic rxd,
   input wire logic watchdog_trigger,
   input wire logic regulator_shutoff_in_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   enter_normal_a:
      assert property (clk_en && go_normal && !normal_active |=> transceiver_on_input)
      else $error("normal entry missed");
   enter_sleep_a:
      assert property (clk_en && go_sleep && !go_normal && normal_active
         |=> !transceiver_on_input) else $error("sleep entry missed");
   sleep_txd_a:
      assert property (!transceiver_on_input |-> txd) else $error("txd low in sleep");
   tx_take_a:
      assert property (clk_en && tx_bit_valid && tx_bit_ready && !go_sleep
         |=> txd == $past(tx_bit) && !tx_bit_ready) else $error("bit not sent");
   rx_follow_a:
      assert property ($past(nrst, 3) && $past(clk_en, 1) && $past(clk_en, 2)
         && $past(clk_en, 3) |-> rx_bit == $past(rxd, 3)) else $error("rx lag");
   wd_high_a:
      assert property ($rose(watchdog_trigger) |-> watchdog_trigger[*8] ##1
         watchdog_trigger[*8] ##1 !watchdog_trigger) else $error("trigger high time");
   wd_low_a:
      assert property ($fell(watchdog_trigger) |-> !watchdog_trigger[*8] ##1
         !watchdog_trigger[*8]) else $error("trigger low time");
   shutoff_a:
      assert property (clk_en |=> regulator_shutoff_in_n == $past(reg_enable))
      else $error("shutoff pin");
   wake_pulse_a:
      assert property (wake_event |-> !transceiver_on_input ##1 !wake_event)
      else $error("wake pulse");
   cover property (wake_event);
   cover property (tx_bit_valid && tx_bit_ready);
   cover property ($rose(watchdog_trigger));
endmodule // lintmc_ctrl_chk

bind lintmc_ctrl lintmc_ctrl_chk i_chk (.*);

/* File: test/lintmc_xcvr_model.sv */
// Behavioural transceiver as seen from the controller's pins
`timescale 1ns/1ps
module lintmc_xcvr_model (
   // Controller side
   input wire logic transceiver_on_input,
   input wire logic txd,
   input wire logic watchdog_trigger,
   input wire logic regulator_shutoff_in_n,
   // Bus and observation
   input wire logic bus_dom,
   output logic     rxd,
   output logic     regulator_control_out,
   output int       wd_edges
);
   logic wake_r = 1'b0;
   wire  bus = ~bus_dom & (txd | ~transceiver_on_input);
   initial wd_edges = 0;
   always @(posedge watchdog_trigger) wd_edges++;
   // Flag survives bus release until normal mode
   always @(transceiver_on_input or bus_dom) begin
      if (transceiver_on_input) wake_r = 1'b0;
      else if (bus_dom) wake_r = 1'b1;
   end
   assign rxd = transceiver_on_input ? bus : ~wake_r;
   assign regulator_control_out = transceiver_on_input | wake_r;
endmodule // lintmc_xcvr_model

/* File: test/testbench.sv */
// Self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
module testbench;
   logic core_clk, nrst, go_normal, go_sleep, tx_bit_valid, tx_bit, wd_kick, reg_enable, bus_dom;
   logic tx_bit_ready, rx_bit, wake_event, normal_active, transceiver_on_input, txd, rxd;
   logic watchdog_trigger, regulator_shutoff_in_n, regulator_control_out, b, clk_en;
   logic [6:0] e, prev, q[$];
   int   num_errors, checks_done, i, wd_edges;
   wire [6:0] obs = {transceiver_on_input, normal_active, txd, rx_bit, watchdog_trigger,
                     regulator_shutoff_in_n, wake_event};
   lintmc_ctrl i_dut (.*);
   lintmc_xcvr_model i_xcvr (.*);
   task automatic chk(string n, logic [11:0] s, logic [11:0] x);
      checks_done++;
      if (s !== x) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic note(int p, logic v);
      e[p] = v;
      q.push_back(e);
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic results;
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Every pin change must match the oldest note
   always @(negedge core_clk) begin
      if (nrst && obs !== prev) begin
         chk("pins", 12'(obs), 12'(q.size() ? q.pop_front() : ~obs));
         prev = obs;
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      #500000;
      num_errors++;
      results();
   end
   initial begin
      {nrst, go_normal, go_sleep, tx_bit_valid, tx_bit, wd_kick, bus_dom} = 7'h00;
      reg_enable = 1'b1;
      clk_en = 1'b1;
      e = 7'h1A;
      prev = 7'h1A;
      i = $urandom(85);
      tick(3);
      nrst = 1'b1;
      // Offers in sleep must leave txd alone
      tx_bit = 1'b0;
      pulse(tx_bit_valid);
      tick(20);
      e[6] = 1'b1;
      note(5, 1'b1);
      pulse(go_normal);
      tick(5);
      // Last bit is recessive so sleep entry sees idle txd
      for (int k = 0; k < 5; k++) begin
         b = (k == 4) ? 1'b1 : 1'($urandom);
         if (b !== e[4]) begin
            note(4, b);
            note(3, b);
         end
         for (i = 0; i < 3000 && !tx_bit_ready; i++) tick(1);
         chk("ready", 12'(tx_bit_ready), 12'h001);
         if (k > 0) chk("bit wait", 12'(i), 12'(lintmc_pkg::BIT_CYC));
         tx_bit = b;
         pulse(tx_bit_valid);
      end
      tick(2010);
      note(3, 1'b0);
      note(3, 1'b1);
      pulse(bus_dom);
      tick(10);
      note(2, 1'b1);
      note(2, 1'b0);
      pulse(wd_kick);
      tick(5);
      pulse(wd_kick);
      tick(40);
      chk("edges", 12'(wd_edges), 12'h001);
      // Frozen controller must ignore a sleep request
      clk_en = 1'b0;
      pulse(go_sleep);
      tick(3);
      clk_en = 1'b1;
      tick(3);
      note(1, 1'b0);
      note(1, 1'b1);
      reg_enable = 1'b0;
      tick(1);
      reg_enable = 1'b1;
      tick(5);
      e[6] = 1'b0;
      note(5, 1'b0);
      pulse(go_sleep);
      tick(10);
      note(3, 1'b0);
      note(0, 1'b1);
      note(0, 1'b0);
      bus_dom = 1'b1;
      tick(20);
      bus_dom = 1'b0;
      tick(30);
      e[6] = 1'b1;
      note(5, 1'b1);
      note(3, 1'b1);
      pulse(go_normal);
      tick(20);
      chk("left", 12'(q.size()), 12'h000);
      results();
   end
endmodule // testbench
